// File: rtl/proximity_measurement_control.sv
`timescale 1ns/1ps
// What this block does
// - Mode codes 00 and 01 mean standby; codes 10 and 11 mean active.
// - Proximity channel leaves reset in standby with mode field zero.
// - Standby makes no measurements but all registers stay readable and the control registers writable.
// - The serial slave keeps working in standby and in active mode.
// - Control bit 5 enables the saturation flag in result upper byte bit 7.
// - Frequency code 000..111 gives 30..100 kHz in 10 kHz steps, reset 011.
// - Duty code 00..11 gives 25, 50, 75, 100 percent, reset 11.
// - Peak current code 0..3 gives 5..50 mA, higher codes 100 mA, reset 111.
// - Emit as many pulses as the count field, 1..15, reset 0001.
// - Active mode repeats measurements and updates results once per interval.
// - Repeat codes map to 50..2000 ms, any 1xxx gives 10 ms, reset 0010.
// - Slave answers at seven-bit address 0x23 plus the host's read/write bit.
// - Writing a result sets the new-data flag; reading the result clears it.
module proximity_measurement_control
  import prox_pkg::*;
#(
  parameter int MS_CYCLES = CLK_HZ / MS_PER_S
) (
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  input wire logic I_SCL,
  input wire logic I_SDA,
  output logic O_SDA_OUT,
  output logic O_SDA_OE,
  input wire logic [10:0] I_PROX_SAMPLE,
  input wire logic I_PROX_SAT,
  output logic O_EMIT,
  output logic [2:0] O_LED_CURRENT,
  output logic O_ACTIVE
);
  typedef enum logic [1:0] {M_STBY, M_WAIT, M_BURST} meas_e;
  meas_e mstate;
  logic [7:0] mode_ctl, drive, pulses, rate, res_lo, res_hi;
  logic new_flag;
  logic [15:0] ms_cnt, ph_cnt;
  logic [10:0] ms_left;
  logic [3:0] pulse_left;
  logic wr, rd;
  logic [7:0] ptr, wdata;
  logic [7:0] rdata;

  // ----------------------------------------------------------------
  // Serial register port
  // ----------------------------------------------------------------
  i2c_reg_slave u_slave (
    .i_clk(I_REF_CLK),
    .i_rst_n(I_RST_N),
    .i_scl(I_SCL),
    .i_sda(I_SDA),
    .o_sda_oe(O_SDA_OE),
    .o_wr(wr),
    .o_rd(rd),
    .o_ptr(ptr),
    .o_wdata(wdata),
    .i_rdata(rdata)
  );

  // ----------------------------------------------------------------
  // Decode and read mux
  // ----------------------------------------------------------------
  wire active = mode_ctl[MODE_ACT_BIT];
  wire rd_result = rd && (ptr == OFS_RES_LO || ptr == OFS_RES_HI);
  always_comb begin
    case (ptr)
      OFS_MODE: rdata = mode_ctl;
      OFS_DRIVE: rdata = drive;
      OFS_PULSES: rdata = pulses;
      OFS_RATE: rdata = rate;
      OFS_STATUS: rdata = 8'(new_flag) << NEW_BIT;
      OFS_RES_LO: rdata = res_lo;
      OFS_RES_HI: rdata = res_hi;
      default: rdata = 8'h00;
    endcase
  end

  // Register writes; accepted in either mode
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      mode_ctl <= RST_MODE;
      drive <= RST_DRIVE;
      pulses <= RST_PULSES;
      rate <= RST_RATE;
    end else if (wr) begin
      // Reserved bits masked so they read zero even if the host misbehaves
      if (ptr == OFS_MODE) mode_ctl <= wdata & MSK_MODE;
      if (ptr == OFS_DRIVE) drive <= wdata;
      if (ptr == OFS_PULSES) pulses <= wdata & MSK_PULSES;
      if (ptr == OFS_RATE) rate <= wdata & MSK_RATE;
    end
  end

  // ----------------------------------------------------------------
  // Emitter timing
  // ----------------------------------------------------------------
  // Period rounds down, so the real rate is a shade above nominal
  wire [31:0] f_hz = F_BASE_HZ + F_STEP_HZ * 32'(drive[7:5]);
  wire [15:0] period = 16'(CLK_HZ / f_hz);
  wire [17:0] on_prod = 18'(period) * 18'({1'b0, drive[4:3]} + 3'h1);
  wire [15:0] on_cyc = 16'(on_prod >> 2);
  wire [3:0] n_pulses = (pulses[3:0] == 4'h0) ? MIN_PULSES : pulses[3:0];
  wire [10:0] interval_ms = repeat_ms(rate[3:0]);
  wire ms_tick = ms_cnt == 16'(MS_CYCLES - 1);
  wire interval_end = mstate != M_STBY && ms_tick && ms_left == 11'd1;
  wire period_end = ph_cnt == period - 16'h1;
  wire meas_done = mstate == M_BURST && period_end && pulse_left == 4'h1;
  wire next_emit = mstate == M_BURST && active && ph_cnt < on_cyc;

  // Interval clock runs through the burst so spacing stays exact;
  // standby preloads a full interval so the first burst waits one too
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      ms_cnt <= 16'h0;
      ms_left <= 11'd1;
    end else if (mstate == M_STBY) begin
      ms_cnt <= 16'h0;
      ms_left <= interval_ms;
    end else begin
      ms_cnt <= ms_tick ? 16'h0 : ms_cnt + 16'h1;
      if (ms_tick) ms_left <= (ms_left == 11'd1) ? interval_ms : ms_left - 11'd1;
    end
  end

  // Measurement sequencer
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N || !active) begin
      mstate <= M_STBY;
      ph_cnt <= 16'h0;
      pulse_left <= 4'h0;
    end else begin
      case (mstate)
        M_STBY: mstate <= M_WAIT;
        M_WAIT: begin
          ph_cnt <= 16'h0;
          pulse_left <= n_pulses;
          if (interval_end) mstate <= M_BURST;
        end
        M_BURST: begin
          ph_cnt <= period_end ? 16'h0 : ph_cnt + 16'h1;
          if (period_end) pulse_left <= pulse_left - 4'h1;
          if (meas_done) mstate <= M_WAIT;
        end
        default: mstate <= M_STBY;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Result and new-data flag
  // ----------------------------------------------------------------
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      res_lo <= 8'h00;
      res_hi <= 8'h00;
      new_flag <= 1'b0;
    end else begin
      if (meas_done) begin
        res_lo <= I_PROX_SAMPLE[7:0];
        res_hi <= {I_PROX_SAT & mode_ctl[SAT_EN_BIT], 4'h0, I_PROX_SAMPLE[10:8]};
      end
      // Set beats a clear in the same cycle
      if (meas_done) new_flag <= 1'b1;
      else if (rd_result) new_flag <= 1'b0;
    end
  end

  // Pins
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      O_EMIT <= 1'b0;
      O_LED_CURRENT <= RST_DRIVE[2:0];
      O_ACTIVE <= 1'b0;
      O_SDA_OUT <= 1'b0;
    end else begin
      O_EMIT <= next_emit;
      O_LED_CURRENT <= drive[2:0];
      O_ACTIVE <= active;
      O_SDA_OUT <= 1'b0; // Open drain: only pulls low
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [4:0] rise_cnt;
  logic [15:0] hi_len;
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N || mstate != M_BURST) rise_cnt <= 5'h0;
    else if (next_emit && !O_EMIT) rise_cnt <= rise_cnt + 5'h1;
    hi_len <= O_EMIT ? hi_len + 16'h1 : 16'h0;
  end

  AST_RESET_STBY: assert property (@(posedge I_REF_CLK)
    !I_RST_N |=> mode_ctl == 8'h00 && mstate == M_STBY)
    else $error("not in standby after reset");
  AST_STBY_QUIET: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    !active |=> ##1 !O_EMIT && !$rose(new_flag))
    else $error("emitter active in standby");
  AST_MODE_DECODE: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    O_ACTIVE == $past(mode_ctl[1]))
    else $error("active output disagrees with mode");
  AST_SAT_FLAG: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    meas_done |=> res_hi[SAT_FLAG_BIT] == $past(I_PROX_SAT && mode_ctl[SAT_EN_BIT]))
    else $error("saturation flag wrong");
  // Full duty merges a burst into one lit stretch, so it shows a single rise
  AST_PULSE_NUM: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    meas_done && active |-> rise_cnt == ((drive[4:3] == 2'h3) ? 5'h1 : 5'(n_pulses)))
    else $error("pulse count wrong");
  // In the cycle of the fall the length counter still holds the lit cycles
  AST_ON_WIDTH: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    $fell(O_EMIT) && active && drive[4:3] != 2'h3 && !$past(wr, 2) |-> hi_len == on_cyc)
    else $error("pulse width wrong");
  AST_NEW_SET: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    meas_done |=> new_flag ##0 res_lo == $past(I_PROX_SAMPLE[7:0]))
    else $error("result not flagged");
  AST_NEW_CLR: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    rd_result && !meas_done |=> !new_flag)
    else $error("flag not cleared by read");
  AST_BURST_START: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    mstate == M_WAIT && interval_end && active |=> mstate == M_BURST [*2])
    else $error("interval end did not start burst");
  AST_RATE_LOAD: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    mstate != M_STBY && ms_tick && ms_left == 11'd1 && active |=> ms_left == $past(interval_ms))
    else $error("interval reload wrong");
  COV_MEAS: cover property (@(posedge I_REF_CLK) disable iff (!I_RST_N) meas_done);
  COV_SAT: cover property (@(posedge I_REF_CLK) disable iff (!I_RST_N) meas_done && I_PROX_SAT);
  COV_RD_ACTIVE: cover property (@(posedge I_REF_CLK) disable iff (!I_RST_N) rd_result && active);
endmodule : proximity_measurement_control

// File: pkg/prox_pkg.sv
package prox_pkg;
  // ----------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR = 7'h23;
  localparam logic [7:0] OFS_MODE = 8'h81;
  localparam logic [7:0] OFS_DRIVE = 8'h82;
  localparam logic [7:0] OFS_PULSES = 8'h83;
  localparam logic [7:0] OFS_RATE = 8'h84;
  localparam logic [7:0] OFS_STATUS = 8'h8c;
  localparam logic [7:0] OFS_RES_LO = 8'h8d;
  localparam logic [7:0] OFS_RES_HI = 8'h8e;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_DRIVE = 8'h7f;
  localparam logic [7:0] RST_PULSES = 8'h01;
  localparam logic [7:0] RST_RATE = 8'h02;
  // Writable bit masks; reserved bits read as zero
  localparam logic [7:0] MSK_MODE = 8'h23;
  localparam logic [7:0] MSK_PULSES = 8'h0f;
  localparam logic [7:0] MSK_RATE = 8'h0f;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MODE_ACT_BIT = 1;
  localparam int SAT_EN_BIT = 5;
  localparam int SAT_FLAG_BIT = 7;
  localparam int NEW_BIT = 0;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int MS_PER_S = 1000;
  localparam int F_BASE_HZ = 30000;
  localparam int F_STEP_HZ = 10000;
  localparam logic [3:0] MIN_PULSES = 4'h1;

  // Repeat interval in ms per rate code
  function automatic logic [10:0] repeat_ms(input logic [3:0] c);
    logic [10:0] r;
    r = 11'd10;
    if (!c[3]) begin
      case (c[2:0])
        3'h0: r = 11'd50;
        3'h1: r = 11'd70;
        3'h2: r = 11'd100;
        3'h3: r = 11'd200;
        3'h4: r = 11'd500;
        3'h5: r = 11'd1000;
        default: r = 11'd2000;
      endcase
    end
    return r;
  endfunction : repeat_ms
endpackage : prox_pkg

// File: rtl/i2c_reg_slave.sv
`timescale 1ns/1ps
module i2c_reg_slave
  import prox_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_oe,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_ptr,
  output logic [7:0] o_wdata,
  input wire logic [7:0] i_rdata
);
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_REG, S_WR, S_RD} st_e;
  st_e state;
  logic scl_q, sda_q, ack;
  logic [3:0] cnt;
  logic [7:0] shreg;

  // ----------------------------------------------------------------
  // Bus event decode
  // ----------------------------------------------------------------
  wire rise = i_scl & ~scl_q;
  wire fall = ~i_scl & scl_q;
  wire start = scl_q & i_scl & sda_q & ~i_sda;
  wire stop = scl_q & i_scl & ~sda_q & i_sda;
  wire byte_end = fall & ~ack & (cnt == 4'h8);
  wire hit = shreg[7:1] == SLAVE_ADDR;

  // Byte engine, alive in every mode of the sensor
  always_ff @(posedge i_clk) begin
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    scl_q <= i_scl;
    sda_q <= i_sda;
    if (!i_rst_n) begin
      state <= S_IDLE;
      {ack, o_sda_oe, scl_q, sda_q} <= 4'hf & 4'h3;
      cnt <= 4'h0;
      shreg <= 8'h00;
      o_ptr <= 8'h00;
      o_wdata <= 8'h00;
    end else if (start) begin
      state <= S_ADDR;
      {ack, o_sda_oe} <= 2'b00;
      cnt <= 4'h0;
    end else if (stop) begin
      state <= S_IDLE;
      {ack, o_sda_oe} <= 2'b00;
    end else if (state != S_IDLE) begin
      if (rise && !ack && state != S_RD) begin
        shreg <= {shreg[6:0], i_sda};
        cnt <= cnt + 4'h1;
      end else if (rise && ack && state == S_RD && i_sda) begin
        state <= S_IDLE; // Master NACK ends the read
        ack <= 1'b0;
      end else if (byte_end) begin
        ack <= 1'b1;
        cnt <= 4'h0;
        o_sda_oe <= state != S_RD && (state != S_ADDR || hit);
        if (state == S_ADDR && !hit) state <= S_IDLE;
        if (state == S_REG) o_ptr <= shreg;
        if (state == S_WR) begin
          o_wr <= 1'b1;
          o_wdata <= shreg;
        end
      end else if (fall && ack) begin
        ack <= 1'b0;
        o_sda_oe <= 1'b0;
        if (state == S_WR) o_ptr <= o_ptr + 8'h01;
        if (state == S_ADDR) state <= shreg[0] ? S_RD : S_REG;
        if (state == S_REG) state <= S_WR;
        if ((state == S_ADDR && shreg[0]) || state == S_RD) begin
          o_rd <= 1'b1;
          o_sda_oe <= ~i_rdata[7];
          shreg <= {i_rdata[6:0], 1'b0};
          cnt <= 4'h1;
        end
      end else if (fall && state == S_RD) begin
        o_sda_oe <= ~shreg[7];
        shreg <= {shreg[6:0], 1'b0};
        cnt <= cnt + 4'h1;
      end
    end
  end

  AST_ADDR_ACK: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    byte_end && !start && !stop && state == S_ADDR && hit |=> o_sda_oe && ack)
    else $error("address match not acknowledged");
  AST_NO_FOREIGN: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    byte_end && !start && !stop && state == S_ADDR && !hit |=> !o_sda_oe && state == S_IDLE)
    else $error("foreign address acknowledged");
  COV_WRITE: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_wr);
  COV_READ: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_rd);
endmodule : i2c_reg_slave

// File: tb/i2c_host_model.sv
`timescale 1ns/1ps
module i2c_host_model
  import prox_pkg::*;
#(
  parameter int HALF = 4
) (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_pull
);
  // ----------------------------------------------------------------
  // Bus master phases, all moves on the falling clock edge
  // ----------------------------------------------------------------
  initial begin
    o_scl = 1'b1;
    o_sda_pull = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge i_clk);
  endtask : wt

  // Start or repeated start: SDA falls while SCL is high
  task automatic start_cond();
    wt(1);
    o_sda_pull = 1'b0;
    wt(HALF);
    o_scl = 1'b1;
    wt(HALF);
    o_sda_pull = 1'b1;
    wt(HALF);
    o_scl = 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    wt(1);
    o_sda_pull = 1'b1;
    wt(HALF);
    o_scl = 1'b1;
    wt(HALF);
    o_sda_pull = 1'b0;
    wt(HALF);
  endtask : stop_cond

  // Data moves one cycle after SCL falls, so the slave never sees a false start
  task automatic clk_bit(input logic pull, output logic seen);
    wt(1);
    o_sda_pull = pull;
    wt(HALF);
    o_scl = 1'b1;
    wt(HALF);
    seen = i_sda;
    o_scl = 1'b0;
  endtask : clk_bit

  task automatic tx(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(~b[i], s);
    clk_bit(1'b0, s);
    ack = ~s;
  endtask : tx

  task automatic rx(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(1'b0, d[i]);
    clk_bit(~nack, s);
  endtask : rx

  task automatic probe(input logic [6:0] addr, output logic ack);
    start_cond();
    tx({addr, 1'b0}, ack);
    stop_cond();
  endtask : probe

  // Caller keeps reserved bits zero in every data byte
  task automatic write_reg(input logic [7:0] ptr, input logic [7:0] data, output logic ok);
    logic a0, a1, a2;
    start_cond();
    tx({SLAVE_ADDR, 1'b0}, a0);
    tx(ptr, a1);
    tx(data, a2);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask : write_reg

  // Pointer write, repeated start, one byte closed by NACK
  task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start_cond();
    tx({SLAVE_ADDR, 1'b0}, a0);
    tx(ptr, a1);
    start_cond();
    tx({SLAVE_ADDR, 1'b1}, a2);
    rx(1'b1, d);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask : read_reg
endmodule : i2c_host_model

// File: tb/test_proximity_measurement_control.sv
`timescale 1ns/1ps
module test_proximity_measurement_control;
  import prox_pkg::*;
  localparam int MS = 100;
  localparam int LIMIT = 60000;
  logic clk, rst_n, scl, pull, sda_out, sda_oe, emit, active, sat, ok, prev_emit, prev_act;
  logic [10:0] sample;
  logic [2:0] led_cur;
  logic [7:0] d;
  int num_errors, comparisons, cycles, rises, high_cnt, t_act;
  wire sda = !pull && !(sda_oe && !sda_out);

  proximity_measurement_control #(.MS_CYCLES(MS)) proximity_measurement_control_i (
    .I_REF_CLK(clk), .I_RST_N(rst_n), .I_SCL(scl), .I_SDA(sda), .O_SDA_OUT(sda_out),
    .O_SDA_OE(sda_oe), .I_PROX_SAMPLE(sample), .I_PROX_SAT(sat), .O_EMIT(emit),
    .O_LED_CURRENT(led_cur), .O_ACTIVE(active));
  i2c_host_model i2c_host_model_i (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_pull(pull));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Emitter and mode watch; also cuts a hang short
  always @(posedge clk) begin
    cycles++;
    if (emit === 1'b1) high_cnt++;
    if (emit === 1'b1 && prev_emit !== 1'b1) rises++;
    if (active === 1'b1 && prev_act !== 1'b1) t_act = cycles;
    prev_emit = emit;
    prev_act = active;
    if (cycles == LIMIT) begin
      num_errors++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Checks and bus helpers
  // ----------------------------------------------------------------
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp_byte

  task automatic cmp_count(input int got, input int lo, input int hi, input string what);
    comparisons++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("[ERR] %0t %s got %0d exp %0d..%0d", $time, what, got, lo, hi);
    end
  endtask : cmp_count

  task automatic wr(input logic [7:0] ptr, input logic [7:0] v);
    i2c_host_model_i.write_reg(ptr, v, ok);
    cmp_byte({7'h0, ok}, 8'h01, "write ack");
  endtask : wr

  task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] exp);
    i2c_host_model_i.read_reg(ptr, d, ok);
    cmp_byte({7'h0, ok}, 8'h01, "read ack");
    cmp_byte(d, exp, $sformatf("reg %h", ptr));
  endtask : rd_chk

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    cmp_byte({7'h0, active}, 8'h00, "active after reset");
    cmp_byte({5'h0, led_cur}, 8'h07, "current after reset");
    rd_chk(OFS_MODE, 8'h00);
    rd_chk(OFS_DRIVE, 8'h7f);
    rd_chk(OFS_PULSES, 8'h01);
    rd_chk(OFS_RATE, 8'h02);
    rd_chk(OFS_STATUS, 8'h00);
    rd_chk(OFS_RES_HI, 8'h00);
    $display("test reset done");
  endtask : t_reset

  // Standby access, foreign address, read-only and unmapped places, every current code
  task automatic t_regs();
    i2c_host_model_i.probe(7'h24, ok);
    cmp_byte({7'h0, ok}, 8'h00, "foreign address");
    wr(OFS_MODE, 8'h20 & MSK_MODE);
    rd_chk(OFS_MODE, 8'h20);
    wr(OFS_PULSES, 8'h0f);
    rd_chk(OFS_PULSES, 8'h0f);
    wr(OFS_RATE, 8'h05);
    rd_chk(OFS_RATE, 8'h05);
    wr(OFS_STATUS, 8'h01);
    rd_chk(OFS_STATUS, 8'h00);
    rd_chk(8'h80, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(OFS_DRIVE, {3'h4, 2'h1, 3'(c)});
      repeat (2) @(negedge clk);
      cmp_byte({5'h0, led_cur}, 8'(c), "current code");
      rd_chk(OFS_DRIVE, {3'h4, 2'h1, 3'(c)});
    end
    $display("test regs done");
  endtask : t_regs

  // Long repeat rate set above keeps bursts out of this test
  task automatic t_mode();
    for (int m = 0; m < 4; m++) begin
      wr(OFS_MODE, 8'(m));
      repeat (3) @(negedge clk);
      cmp_byte({7'h0, active}, {7'h0, 1'(m >> 1)}, "mode decode");
      rd_chk(OFS_MODE, 8'(m));
    end
    wr(OFS_MODE, 8'h00);
    $display("test mode done");
  endtask : t_mode

  // 100 kHz, 25 % duty, three pulses: 200-cycle period, 50 cycles lit each
  task automatic t_measure(input logic [3:0] rc, input int ms, input logic [7:0] md,
                           input logic [7:0] hi);
    int r0, h0;
    wr(OFS_DRIVE, 8'he7);
    wr(OFS_PULSES, 8'h03);
    wr(OFS_RATE, {4'h0, rc});
    r0 = rises;
    h0 = high_cnt;
    wr(OFS_MODE, md);
    for (int k = 0; k < ms * MS + 200 && rises == r0; k++) @(negedge clk);
    cmp_count(cycles - t_act, ms * MS - 2, ms * MS + 4, "first burst delay");
    repeat (620) @(negedge clk);
    cmp_count(rises - r0, 3, 3, "pulse count");
    cmp_count(high_cnt - h0, 150, 150, "lit cycles");
    wr(OFS_MODE, 8'h00);
    rd_chk(OFS_STATUS, 8'h01);
    rd_chk(OFS_RES_LO, 8'ha3);
    rd_chk(OFS_RES_HI, hi);
    rd_chk(OFS_STATUS, 8'h00);
    r0 = rises;
    repeat (1200) @(negedge clk);
    cmp_count(rises - r0, 0, 0, "standby pulses");
    $display("test measure rate %h done", rc);
  endtask : t_measure

  task automatic report_and_stop();
    $display("comparisons=%0d errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  initial begin
    rst_n = 1'b0;
    sample = 11'h5a3;
    sat = 1'b1;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    t_reset();
    t_regs();
    t_mode();
    t_measure(4'h0, 50, 8'h22, 8'h85);
    t_measure(4'h8, 10, 8'h03, 8'h05);
    report_and_stop();
  end
endmodule : test_proximity_measurement_control
